// >>> design/ficr_pkg.sv
// Constants for the fail-safe, init timer and CRC reference register block
// What this block does
// RULE1 - In fail-safe state, bit 4 set applies one-fail-all-fail to outputs.
// RULE2 - Init timer length comes from the 4-bit code in bits 3-0.
// RULE3 - 8-bit read/write CRC reference, loaded from EEPROM at reset.
// RULE4 - Factory CRC reference is 1Bh for base part, 75h for alternate.
// RULE5 - Software never changes unlisted control-area offsets; they stay reserved.
// RULE6 - Init timer codes 8h to Fh continue the descending time sequence.
package ficr_pkg;

	// Clock and time base
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int TICK_NS         = 1000;
	localparam int US_CYCLES       = (TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CFG    = 8'h86;
	localparam logic [7:0] IDX_CRC    = 8'h87;
	localparam logic [7:0] IDX_STATUS = 8'hA0;
	localparam logic [7:0] IDX_CTRL   = 8'hA1;

	// Bus widths
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// Configuration register fields
	localparam int ONE_FAIL_ALL_FAIL_ENABLE_BIT     = 4;
	localparam int CODE_LSB     = 0;
	localparam int CODE_W       = 4;
	localparam logic [7:0] CFG_MASK = 8'h1F;

	// Status register fields
	localparam int ST_BUSY  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_MATCH = 2;
	localparam int ST_FS    = 3;
	localparam int ST_ONE_FAIL_ALL_FAIL_ENABLE  = 4;

	// Control register fields
	localparam int CT_RESTART = 0;

	// Reset values before the EEPROM image is taken
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CRC_RESET = 8'h00;

	// Factory CRC reference per part variant
	localparam logic [7:0] CRC_FACTORY_BASE = 8'h1B;
	localparam logic [7:0] CRC_FACTORY_ALT  = 8'h75;

	// Init timer lengths in microseconds, indexed by code
	localparam int TIME_W = 16;
	localparam logic [TIME_W-1:0] INIT_TIME_US [16] = '{
		16'h0000, 16'hC350, 16'h4E20, 16'h2710,
		16'h1388, 16'h07D0, 16'h03E8, 16'h01F4,
		16'h00C8, 16'h0064, 16'h0032, 16'h0014,
		16'h000A, 16'h0005, 16'h0002, 16'h0001
	};

endpackage

// >>> design/ficr_timer_if.sv
// Start and status signals between register block and init timer
`timescale 1ns/1ps
`default_nettype none
interface ficr_timer_if;
	import ficr_pkg::*;

	logic              start;
	logic [CODE_W-1:0] code;
	logic              busy;
	logic              done;

	modport ctrl (output start, output code, input busy, input done);
	modport tmr  (input start, input code, output busy, output done);
endinterface
`default_nettype wire

// >>> design/ficr_init_timer.sv
// Initialization timer driven by a one-microsecond enable
`timescale 1ns/1ps
`default_nettype none
module ficr_init_timer
	import ficr_pkg::*;
#(
	parameter int TICK_CYCLES = US_CYCLES
)
(
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  nrst,
	// Control side
	ficr_timer_if.tmr  tif
);

	typedef enum logic {FICR_IDLE, FICR_RUN} ficr_tstate_e;

	ficr_tstate_e       state_q;
	ficr_tstate_e       state_d;
	logic [TIME_W-1:0]  cnt_q;
	logic [TIME_W-1:0]  cnt_d;
	logic [15:0]        div_q;
	logic [15:0]        div_d;
	logic               done_q;
	logic               done_d;
	logic               tick;
	logic [TIME_W-1:0]  load;

	assign load = INIT_TIME_US[tif.code];   // [RULE2] [RULE6]
	assign tick = (div_q == 16'(TICK_CYCLES - 1));

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		div_d   = div_q;
		done_d  = done_q;
		if (tif.start)
		begin
			div_d = 16'h0000;
			cnt_d = load;
			if (load == 16'h0000)
			begin
				state_d = FICR_IDLE;
				done_d  = 1'b1;
			end
			else
			begin
				state_d = FICR_RUN;
				done_d  = 1'b0;
			end
		end
		else
		begin
			case (state_q)
				FICR_RUN:
				begin
					div_d = tick ? 16'h0000 : div_q + 16'h0001;
					if (tick)
					begin
						cnt_d = cnt_q - 16'h0001;
						if (cnt_q == 16'h0001)
						begin
							state_d = FICR_IDLE;
							done_d  = 1'b1;
						end
					end
				end
				default:
				begin
					div_d = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= FICR_IDLE;
			cnt_q   <= '0;
			div_q   <= 16'h0000;
			done_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			div_q   <= div_d;
			done_q  <= done_d;
		end
	end

	assign tif.busy = (state_q == FICR_RUN);
	assign tif.done = done_q;

endmodule
`default_nettype wire

// >>> design/ficr_regs.sv
// Fail-safe, init timer and CRC reference registers with Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module ficr_regs
	import ficr_pkg::*;
#(
	parameter int CHANNELS    = 24,
	parameter bit VARIANT_ALT = 1'b0,
	parameter int TICK_CYCLES = US_CYCLES
)
(
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                nrst,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0]   avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [DATA_W-1:0]   avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [DATA_W-1:0]   avs_readdata,
	output logic                     avs_waitrequest,
	// EEPROM image
	input  wire logic [7:0]          eep_cfg,
	input  wire logic [7:0]          eep_crc,
	// Fail-safe and channels
	input  wire logic                failsafe_state,
	input  wire logic [CHANNELS-1:0] chan_fault,
	output logic      [CHANNELS-1:0] chan_off,
	output logic                     one_fail_all_fail_enable_active,
	output logic                     one_fail_all_fail_enable,
	output logic      [CODE_W-1:0]   init_timer_code
);

	localparam logic [ADDR_W-1:0] ADDR_CFG    = {IDX_CFG, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CRC    = {IDX_CRC, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
	localparam logic [7:0] CRC_FACTORY = VARIANT_ALT ? CRC_FACTORY_ALT : CRC_FACTORY_BASE;

	ficr_timer_if tif ();

	// Register state
	logic [7:0]          cfg_q;
	logic [7:0]          cfg_d;
	logic [7:0]          crc_q;
	logic [7:0]          crc_d;
	logic                load_pend_q;
	logic                start_q;
	logic                start_d;
	// Bus state
	logic                wait_q;
	logic                wait_d;
	logic [DATA_W-1:0]   rdata_q;
	logic [DATA_W-1:0]   rdata_d;
	// Channel state
	logic [CHANNELS-1:0] off_q;
	logic [CHANNELS-1:0] off_d;
	logic                one_fail_all_fail_enable_act_q;
	logic                one_fail_all_fail_enable_act_d;

	logic                req;
	logic                wr_commit;
	logic                any_fault;
	logic                crc_match;
	logic [7:0]          status;

	assign req       = (avs_read || avs_write) && !load_pend_q;
	assign wr_commit = avs_write && !wait_q && avs_byteenable[0];
	assign any_fault = |chan_fault;
	assign crc_match = (crc_q == CRC_FACTORY);   // [RULE4]

	always_comb
	begin
		status           = 8'h00;
		status[ST_BUSY]  = tif.busy;
		status[ST_DONE]  = tif.done;
		status[ST_MATCH] = crc_match;
		status[ST_FS]    = failsafe_state;
		status[ST_ONE_FAIL_ALL_FAIL_ENABLE]  = one_fail_all_fail_enable_act_q;
	end

	// Configuration and CRC reference
	always_comb
	begin
		cfg_d   = cfg_q;
		crc_d   = crc_q;
		start_d = 1'b0;
		if (load_pend_q)
		begin
			cfg_d   = eep_cfg & CFG_MASK;   // [RULE1] [RULE2]
			crc_d   = eep_crc;              // [RULE3]
			start_d = 1'b1;
		end
		else if (wr_commit)
		begin
			if (avs_address == ADDR_CFG)
			begin
				cfg_d = avs_writedata[7:0] & CFG_MASK;
			end
			else if (avs_address == ADDR_CRC)
			begin
				crc_d = avs_writedata[7:0];   // [RULE3]
			end
			else if (avs_address == ADDR_CTRL)
			begin
				start_d = avs_writedata[CT_RESTART];
			end
			// Other offsets take no write [RULE5]
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_q       <= CFG_RESET;
			crc_q       <= CRC_RESET;
			start_q     <= 1'b0;
			load_pend_q <= 1'b1;
		end
		else
		begin
			cfg_q       <= cfg_d;
			crc_q       <= crc_d;
			start_q     <= start_d;
			load_pend_q <= 1'b0;
		end
	end

	assign tif.start = start_q;
	assign tif.code  = cfg_q[CODE_LSB +: CODE_W];   // [RULE2]

	// Bus answer: waitrequest drops for one cycle per request
	always_comb
	begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if (req && wait_q)
		begin
			wait_d  = 1'b0;
			rdata_d = '0;
			if (avs_address == ADDR_CFG)
			begin
				rdata_d[7:0] = cfg_q & CFG_MASK;
			end
			else if (avs_address == ADDR_CRC)
			begin
				rdata_d[7:0] = crc_q;
			end
			else if (avs_address == ADDR_STATUS)
			begin
				rdata_d[7:0] = status;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			wait_q  <= 1'b1;
			rdata_q <= '0;
		end
		else
		begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Channel shut-off in fail-safe state
	assign one_fail_all_fail_enable_act_d = failsafe_state && cfg_q[ONE_FAIL_ALL_FAIL_ENABLE_BIT];   // [RULE1]

	generate
		for (genvar i = 0; i < CHANNELS; i++)
		begin : g_chan
			always_comb
			begin
				off_d[i] = 1'b0;
				if (failsafe_state)
				begin
					off_d[i] = chan_fault[i] || (one_fail_all_fail_enable_act_d && any_fault);   // [RULE1]
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			off_q      <= '0;
			one_fail_all_fail_enable_act_q <= 1'b0;
		end
		else
		begin
			off_q      <= off_d;
			one_fail_all_fail_enable_act_q <= one_fail_all_fail_enable_act_d;
		end
	end

	assign avs_readdata             = rdata_q;
	assign avs_waitrequest          = wait_q;
	assign chan_off                 = off_q;
	assign one_fail_all_fail_enable_active              = one_fail_all_fail_enable_act_q;
	assign one_fail_all_fail_enable = cfg_q[ONE_FAIL_ALL_FAIL_ENABLE_BIT];
	assign init_timer_code          = cfg_q[CODE_LSB +: CODE_W];

	ficr_init_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clock (clock),
		.nrst  (nrst),
		.tif   (tif.tmr)
	);

	// Helper: cycles since last timer start
	logic [31:0] run_cnt_q;
	logic [3:0]  run_code_q;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			run_cnt_q  <= '0;
			run_code_q <= '0;
		end
		else if (start_q)
		begin
			run_cnt_q  <= 32'h0000_0001;
			run_code_q <= tif.code;
		end
		else
		begin
			run_cnt_q  <= run_cnt_q + 32'h0000_0001;
			run_code_q <= run_code_q;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	cfg_write_a: assert property ( // [RULE1] [RULE2]
		wr_commit && avs_address == ADDR_CFG |=>
			one_fail_all_fail_enable == $past(avs_writedata[ONE_FAIL_ALL_FAIL_ENABLE_BIT]) &&
			init_timer_code == $past(avs_writedata[3:0]))
		else $error("config write not stored");

	one_fail_all_fail_enable_apply_a: assert property ( // [RULE1]
		failsafe_state && cfg_q[ONE_FAIL_ALL_FAIL_ENABLE_BIT] && any_fault |=> &chan_off)
		else $error("one fault did not turn all outputs off");

	one_fail_all_fail_enable_skip_a: assert property ( // [RULE1]
		failsafe_state && !cfg_q[ONE_FAIL_ALL_FAIL_ENABLE_BIT] |=> chan_off == $past(chan_fault))
		else $error("outputs off beyond faulty ones with policy disabled");

	normal_run_a: assert property ( // [RULE1]
		!failsafe_state |=> chan_off == '0 && !one_fail_all_fail_enable_active)
		else $error("outputs off outside fail-safe state");

	init_len_a: assert property ( // [RULE2]
		$rose(tif.done) && !$past(start_q) |->
			run_cnt_q == 32'(INIT_TIME_US[run_code_q]) * 32'(TICK_CYCLES) + 32'h0000_0001)
		else $error("init timer length wrong for code");

	crc_write_a: assert property ( // [RULE3]
		wr_commit && avs_address == ADDR_CRC |=> crc_q == $past(avs_writedata[7:0]))
		else $error("crc reference write not stored");

	eep_load_a: assert property ( // [RULE3]
		load_pend_q |=> crc_q == $past(eep_crc) && cfg_q == ($past(eep_cfg) & CFG_MASK) && start_q
			##1 start_q == 1'b0)
		else $error("eeprom image not loaded after reset");

	crc_match_a: assert property ( // [RULE4]
		wr_commit && avs_address == ADDR_CRC && avs_writedata[7:0] == CRC_FACTORY
			|=> ##1 status[ST_MATCH])
		else $error("factory crc match not flagged");

	ack_pulse_a: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	cfg_write_c: cover property (wr_commit && avs_address == ADDR_CFG);
	one_fail_all_fail_enable_hit_c:  cover property (failsafe_state && cfg_q[ONE_FAIL_ALL_FAIL_ENABLE_BIT] && any_fault ##1 &chan_off);
	init_done_c: cover property ($rose(tif.done));
	crc_read_c:  cover property (avs_read && !avs_waitrequest && avs_address == ADDR_CRC);

endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the fail-safe, init timer and CRC reference registers
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ficr_pkg::*;

	typedef struct packed
	{
		logic [9:0]  a;
		logic [7:0]  wd;
		logic [3:0]  be;
		logic [7:0]  rx;
		logic        fs;
		logic [23:0] flt;
		logic [23:0] off;
		logic        act;
	} ficr_row_s;

	logic              clock;
	logic              nrst;
	logic [ADDR_W-1:0] avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [DATA_W-1:0] avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [DATA_W-1:0] avs_readdata;
	logic              avs_waitrequest;
	logic [7:0]        eep_cfg;
	logic [7:0]        eep_crc;
	logic              failsafe_state;
	logic [23:0]       chan_fault;
	logic [23:0]       chan_off;
	logic              one_fail_all_fail_enable_active;
	logic              one_fail_all_fail_enable;
	logic [3:0]        init_timer_code;
	logic [7:0]        cfg_m;
	logic [31:0]       rd;
	int                num_errors = 0;
	int                comparisons = 0;
	int                cyc = 0;
	int                t0;
	int                n;

	// Config and CRC writes, then unmapped places kept clear of the control area
	ficr_row_s rows [7] = '{
		'{10'h218, 8'hFF, 4'hF, 8'h1F, 1'b1, 24'h000008, 24'hFFFFFF, 1'b1},
		'{10'h218, 8'hE3, 4'h1, 8'h03, 1'b1, 24'h000008, 24'h000008, 1'b0},
		'{10'h218, 8'h10, 4'hE, 8'h03, 1'b0, 24'h800001, 24'h000000, 1'b0},
		'{10'h21C, 8'hA5, 4'h1, 8'hA5, 1'b1, 24'h800001, 24'h800001, 1'b0},
		'{10'h000, 8'h5A, 4'hF, 8'h00, 1'b1, 24'h000000, 24'h000000, 1'b0},
		'{10'h3FC, 8'hC3, 4'hF, 8'h00, 1'b1, 24'h000000, 24'h000000, 1'b0},
		'{10'h218, 8'h10, 4'h1, 8'h10, 1'b1, 24'h000000, 24'h000000, 1'b1}
	};
	logic [3:0] codes [14] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF,
		4'h6, 4'h5, 4'h4, 4'h3};
	int         us [14]    = '{0, 500, 200, 100, 50, 20, 10, 5, 2, 1, 1000, 2000, 5000, 10000};

	ficr_regs #(.CHANNELS(24), .VARIANT_ALT(1'b0), .TICK_CYCLES(1)) DUT
	(
		.clock                    (clock),
		.nrst                     (nrst),
		.avs_address              (avs_address),
		.avs_read                 (avs_read),
		.avs_write                (avs_write),
		.avs_writedata            (avs_writedata),
		.avs_byteenable           (avs_byteenable),
		.avs_readdata             (avs_readdata),
		.avs_waitrequest          (avs_waitrequest),
		.eep_cfg                  (eep_cfg),
		.eep_crc                  (eep_crc),
		.failsafe_state           (failsafe_state),
		.chan_fault               (chan_fault),
		.chan_off                 (chan_off),
		.one_fail_all_fail_enable_active              (one_fail_all_fail_enable_active),
		.one_fail_all_fail_enable (one_fail_all_fail_enable),
		.init_timer_code          (init_timer_code)
	);

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	always @(posedge clock)
		cyc <= cyc + 1;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic test_done;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One Avalon-MM transfer; read data lands in rd
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] b);
		int k;
		@(posedge clock);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= b;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (avs_waitrequest !== 1'b0 && k < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0)
		begin
			$display("MISMATCH waitrequest expected 0 seen %b", avs_waitrequest);
			num_errors++;
			test_done;
		end
	endtask

	// Reset with a given EEPROM image, then check what was loaded
	task automatic rst(input logic [7:0] c, input logic [7:0] k);
		@(posedge clock);
		nrst <= 1'b0;
		eep_cfg <= c;
		eep_crc <= k;
		repeat (4) @(posedge clock);
		chk("code_in_reset", 32'h0, 32'(init_timer_code));
		nrst <= 1'b1;
		cfg_m = c & 8'h1F;
		repeat (2) @(negedge clock);
		chk("one_fail_all_fail_enable_enable", 32'(cfg_m[4]), 32'(one_fail_all_fail_enable));
		chk("timer_code", 32'(cfg_m[3:0]), 32'(init_timer_code));
		bus(1'b0, 10'h218, 8'h00, 4'hF);
		chk("cfg_reset", 32'(cfg_m), rd);
		bus(1'b0, 10'h21C, 8'h00, 4'hF);
		chk("crc_reset", 32'(k), rd);
	endtask

	initial
	begin
		nrst = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'h0;
		eep_cfg = 8'h00;
		eep_crc = 8'h00;
		failsafe_state = 1'b0;
		chan_fault = '0;
		rst(8'hF7, 8'h1B);
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].wd, rows[i].be);
			if (rows[i].a == 10'h218 && rows[i].be[0])
				cfg_m = rows[i].wd & 8'h1F;
			bus(1'b0, rows[i].a, 8'h00, 4'hF);
			chk("readback", 32'(rows[i].rx), rd);
			@(posedge clock);
			failsafe_state <= rows[i].fs;
			chan_fault <= rows[i].flt;
			repeat (2) @(negedge clock);
			chk("chan_off", 32'(rows[i].off), 32'(chan_off));
			chk("one_fail_all_fail_enable_active", 32'(rows[i].act), 32'(one_fail_all_fail_enable_active));
			chk("one_fail_all_fail_enable_enable", 32'(cfg_m[4]), 32'(one_fail_all_fail_enable));
			chk("timer_code", 32'(cfg_m[3:0]), 32'(init_timer_code));
		end
		// Restart the timer for every code short enough to run
		for (int i = 0; i < 14; i++)
		begin
			bus(1'b1, 10'h218, {4'h0, codes[i]}, 4'h1);
			bus(1'b1, 10'h284, 8'h01, 4'h1);
			t0 = cyc;
			repeat (3) @(posedge clock);
			bus(1'b0, 10'h280, 8'h00, 4'hF);
			if (us[i] > 9)
				chk("timer_busy", 32'h1, 32'(rd[ST_BUSY]));
			n = 0;
			while (rd[ST_DONE] !== 1'b1 && n < 4000)
			begin
				bus(1'b0, 10'h280, 8'h00, 4'hF);
				n++;
			end
			if (rd[ST_DONE] !== 1'b1)
			begin
				$display("MISMATCH timer_done expected 1 seen %b", rd[ST_DONE]);
				num_errors++;
				test_done;
			end
			chk("timer_time", 32'h1, 32'(cyc - t0 >= us[i] && cyc - t0 <= us[i] + 10));
		end
		// Status is read-only; match bit follows the stored reference
		bus(1'b1, 10'h280, 8'hFF, 4'hF);
		bus(1'b1, 10'h21C, 8'h1B, 4'h1);
		bus(1'b0, 10'h280, 8'h00, 4'hF);
		chk("status_base", 32'h3, 32'(rd[4:2]));
		bus(1'b1, 10'h21C, 8'h75, 4'h1);
		bus(1'b0, 10'h280, 8'h00, 4'hF);
		chk("status_alt", 32'h2, 32'(rd[4:2]));
		rst(8'hE8, 8'h75);
		test_done;
	end
endmodule
`default_nettype wire
